// ### slc_pkg.sv
// constants and field layout of the switch link control and status block
package slc_pkg;
  // ----------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------
  localparam logic [7:0] IDX_RSVD = 8'h11;
  localparam logic [7:0] IDX_DBG = 8'h1F;
  localparam logic [7:0] IDX_EXT_STAT = 8'h20;
  localparam logic [7:0] IDX_PL_STAT = 8'h40;
  localparam logic [7:0] IDX_CFG = 8'h80;
  localparam logic [7:0] IDX_STATIC = 8'hA0;
  localparam int N_LINK = 8;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int B_DBG_RSVD = 4;
  localparam int B_TYPE = 24;
  localparam int B_DEST = 16;
  localparam int B_DIR = 8;
  localparam int B_NET = 4;
  localparam int B_JUNK = 2;
  localparam int B_DST_USE = 1;
  localparam int B_SRC_USE = 0;
  localparam int B_EN = 31;
  localparam int B_WIDE = 30;
  localparam int B_ERR = 27;
  localparam int B_ISSUED = 26;
  localparam int B_HELD = 25;
  localparam int B_GREETING_TOKEN = 24;
  localparam int B_RXRST = 23;
  localparam int B_SYMGAP = 11;
  localparam int B_TOKGAP = 0;
  localparam int B_ST_EN = 31;
  localparam int B_ST_PROC = 8;
  localparam int B_ST_CHAN = 0;
  localparam int GAP_W = 11;
  // ----------------------------------------
  // reset values and static link letter map (A=0 .. H=7)
  // ----------------------------------------
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [GAP_W:0] GAP_ONE = 12'h001;
  localparam logic [7:0][2:0] STATIC_LINK_MAP = {3'h5, 3'h4, 3'h7, 3'h6, 3'h1, 3'h0, 3'h3, 3'h2};
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : slc_pkg

// ### slc_link_tx.sv
// per-link credit tracking and transmit pacing
module slc_link_tx import slc_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // configuration
  input wire logic enable,
  input wire logic [GAP_W-1:0] sym_gap,
  input wire logic [GAP_W-1:0] tok_gap,
  input wire logic greeting_token,
  input wire logic rx_reset,
  // credit events from the link
  input wire logic remote_credit,
  input wire logic local_grant,
  // symbol stream to the wire
  input wire logic sym_valid,
  input wire logic sym_last,
  output logic sym_ready,
  // status
  output logic credit_held,
  output logic credit_issued
);
  typedef struct packed {
    logic held;
    logic issued;
    logic [GAP_W:0] gap;
  } slc_tx_s;

  slc_tx_s s_r;
  slc_tx_s s_nxt;

  // only send with credit, once spacing has run out
  assign sym_ready = enable & s_r.held & ~greeting_token & (s_r.gap == '0);
  assign credit_held = s_r.held;
  assign credit_issued = s_r.issued;

  // next state
  always_comb begin
    s_nxt = s_r;
    if (s_r.gap != '0) begin
      s_nxt.gap = s_r.gap - GAP_ONE;
    end
    if (sym_valid & sym_ready) begin
      if (sym_last) begin
        s_nxt.gap = {1'b0, tok_gap} + GAP_ONE;
      end else begin
        s_nxt.gap = {1'b0, sym_gap} + GAP_ONE;
      end
    end
    // greeting drops own credit; incoming credit wins
    if (greeting_token) begin
      s_nxt.held = 1'b0;
    end
    if (remote_credit) begin
      s_nxt.held = 1'b1;
    end
    // receiver reset withdraws issued credit; new grant wins
    if (rx_reset) begin
      s_nxt.issued = 1'b0;
    end
    if (local_grant) begin
      s_nxt.issued = 1'b1;
    end
    if (!enable) begin
      s_nxt.held = 1'b0;
      s_nxt.issued = 1'b0;
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : slc_link_tx

// ### slc_top.sv
// link control and status registers of the switch, AHB-Lite slave
module slc_top import slc_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // debug event sources, one-cycle pulses
  input wire logic dbg_evt_core0,
  input wire logic dbg_evt_core1,
  // external link route status from switch core
  input wire logic [7:0][1:0] ext_src_type,
  input wire logic [7:0][7:0] ext_dest,
  input wire logic [7:0] ext_junk,
  input wire logic [7:0] ext_dst_use,
  input wire logic [7:0] ext_src_use,
  // processor link route status from switch core
  input wire logic [7:0][1:0] pl_src_type,
  input wire logic [7:0][7:0] pl_dest,
  input wire logic [7:0] pl_junk,
  input wire logic [7:0] pl_dst_use,
  input wire logic [7:0] pl_src_use,
  // link receiver events, one-cycle pulses
  input wire logic [7:0] rx_error,
  input wire logic [7:0] remote_credit,
  input wire logic [7:0] local_grant,
  // transmit symbol streams
  input wire logic [7:0] tx_sym_valid,
  input wire logic [7:0] tx_sym_last,
  output logic [7:0] tx_sym_ready,
  // link controls
  output logic [7:0] link_enable,
  output logic [7:0] link_wide,
  output logic [7:0] link_greeting_token,
  output logic [7:0] link_rx_reset,
  output logic [7:0][3:0] ext_dir,
  output logic [7:0][1:0] ext_net,
  output logic [7:0][1:0] pl_net,
  // static forwarding, indexed by link letter A..H
  output logic [7:0] static_fwd_en,
  output logic [7:0] static_fwd_proc,
  output logic [7:0][4:0] static_fwd_chan
);
  typedef struct packed {
    logic [1:0] rsvd;
    logic dbg_rsvd;
    logic [1:0] dbg_core;
    logic [7:0][3:0] dir;
    logic [7:0][1:0] enet;
    logic [7:0][1:0] pnet;
    logic [7:0] en;
    logic [7:0] wide;
    logic [7:0] err;
    logic [7:0][GAP_W-1:0] symgap;
    logic [7:0][GAP_W-1:0] tokgap;
    logic [7:0] greeting_token;
    logic [7:0] rxrst;
    logic [7:0] st_en;
    logic [7:0] st_proc;
    logic [7:0][4:0] st_chan;
    logic dp_wr;
    logic dp_rd;
    logic rd_done;
    logic dp_hit;
    logic [7:0] dp_idx;
    logic [31:0] rdata;
  } slc_state_s;

  slc_state_s s_r;
  slc_state_s s_nxt;
  logic [7:0] held;
  logic [7:0] issued;

  // true when idx addresses entry i of the bank at base
  function automatic logic bank_hit(input logic [7:0] idx, input logic [7:0] base, input int i);
    bank_hit = (idx == (base + 8'(i)));
  endfunction : bank_hit

  // ----------------------------------------
  // read data decode
  // ----------------------------------------
  function automatic logic [31:0] rd_word(input slc_state_s st, input logic [7:0] idx,
                                          input logic [7:0] hv, input logic [7:0] iv);
    logic [31:0] w;
    w = ZERO_WORD;
    if (idx == IDX_RSVD) begin
      w[1:0] = st.rsvd;
    end
    if (idx == IDX_DBG) begin
      w[B_DBG_RSVD] = st.dbg_rsvd;
      w[1:0] = st.dbg_core;
    end
    for (int i = 0; i < N_LINK; i++) begin
      if (bank_hit(idx, IDX_EXT_STAT, i)) begin
        w[B_TYPE +: 2] = ext_src_type[i];
        w[B_DEST +: 8] = ext_dest[i];
        w[B_DIR +: 4] = st.dir[i];
        w[B_NET +: 2] = st.enet[i];
        w[B_JUNK] = ext_junk[i];
        w[B_DST_USE] = ext_dst_use[i];
        w[B_SRC_USE] = ext_src_use[i];
      end
      if (bank_hit(idx, IDX_PL_STAT, i)) begin
        w[B_TYPE +: 2] = pl_src_type[i];
        w[B_DEST +: 8] = pl_dest[i];
        w[B_NET +: 2] = st.pnet[i];
        w[B_JUNK] = pl_junk[i];
        w[B_DST_USE] = pl_dst_use[i];
        w[B_SRC_USE] = pl_src_use[i];
      end
      if (bank_hit(idx, IDX_CFG, i)) begin
        w[B_EN] = st.en[i];
        w[B_WIDE] = st.wide[i];
        w[B_ERR] = st.err[i];
        w[B_ISSUED] = iv[i];
        w[B_HELD] = hv[i];
        w[B_SYMGAP +: GAP_W] = st.symgap[i];
        w[B_TOKGAP +: GAP_W] = st.tokgap[i];
      end
      if (bank_hit(idx, IDX_STATIC, i)) begin
        w[B_ST_EN] = st.st_en[i];
        w[B_ST_PROC] = st.st_proc[i];
        w[B_ST_CHAN +: 5] = st.st_chan[i];
      end
    end
    rd_word = w;
  endfunction : rd_word

  // ----------------------------------------
  // bus answers
  // ----------------------------------------
  // reads take one wait state so a write just before is seen
  assign hreadyout = ~(s_r.dp_rd & ~s_r.rd_done);
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.greeting_token = '0;
    s_nxt.rxrst = '0;
    // write data phase, only documented writable fields
    if (s_r.dp_wr & s_r.dp_hit) begin
      if (s_r.dp_idx == IDX_RSVD) begin
        s_nxt.rsvd = hwdata[1:0];
      end
      if (s_r.dp_idx == IDX_DBG) begin
        s_nxt.dbg_rsvd = hwdata[B_DBG_RSVD];
        s_nxt.dbg_core = hwdata[1:0];
      end
      for (int i = 0; i < N_LINK; i++) begin
        if (bank_hit(s_r.dp_idx, IDX_EXT_STAT, i)) begin
          s_nxt.dir[i] = hwdata[B_DIR +: 4];
          s_nxt.enet[i] = hwdata[B_NET +: 2];
        end
        if (bank_hit(s_r.dp_idx, IDX_PL_STAT, i)) begin
          s_nxt.pnet[i] = hwdata[B_NET +: 2];
        end
        if (bank_hit(s_r.dp_idx, IDX_CFG, i)) begin
          s_nxt.en[i] = hwdata[B_EN];
          s_nxt.wide[i] = hwdata[B_WIDE];
          s_nxt.greeting_token[i] = hwdata[B_GREETING_TOKEN];
          s_nxt.rxrst[i] = hwdata[B_RXRST];
          s_nxt.symgap[i] = hwdata[B_SYMGAP +: GAP_W];
          s_nxt.tokgap[i] = hwdata[B_TOKGAP +: GAP_W];
        end
        if (bank_hit(s_r.dp_idx, IDX_STATIC, i)) begin
          s_nxt.st_en[i] = hwdata[B_ST_EN];
          s_nxt.st_proc[i] = hwdata[B_ST_PROC];
          s_nxt.st_chan[i] = hwdata[B_ST_CHAN +: 5];
        end
      end
    end
    // receiver reset clears the error flag, a new error wins
    for (int i = 0; i < N_LINK; i++) begin
      if (s_nxt.rxrst[i]) begin
        s_nxt.err[i] = 1'b0;
      end
      if (rx_error[i]) begin
        s_nxt.err[i] = 1'b1;
      end
    end
    // latest debug event names its core, over any write
    if (dbg_evt_core0 | dbg_evt_core1) begin
      s_nxt.dbg_core = {dbg_evt_core1, dbg_evt_core0};
    end
    // read data phase: one wait cycle, then data from flops
    if (s_r.dp_rd & ~s_r.rd_done) begin
      s_nxt.rd_done = 1'b1;
      s_nxt.rdata = s_r.dp_hit ? rd_word(s_r, s_r.dp_idx, held, issued) : ZERO_WORD;
    end
    // address phase
    if (hreadyout & hready) begin
      s_nxt.rd_done = 1'b0;
      if (hsel & (htrans == HTRANS_NONSEQ)) begin
        s_nxt.dp_wr = hwrite;
        s_nxt.dp_rd = ~hwrite;
        s_nxt.dp_idx = haddr[9:2];
        s_nxt.dp_hit = (haddr[31:10] == '0) & (haddr[1:0] == 2'h0);
      end else begin
        s_nxt.dp_wr = 1'b0;
        s_nxt.dp_rd = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // link controls and outputs
  // ----------------------------------------
  assign link_enable = s_r.en;
  assign link_wide = s_r.wide;
  assign link_greeting_token = s_r.greeting_token;
  assign link_rx_reset = s_r.rxrst;
  assign ext_dir = s_r.dir;
  assign ext_net = s_r.enet;
  assign pl_net = s_r.pnet;

  // per-link transmit pacing and credit, static letter remap
  for (genvar g = 0; g < N_LINK; g++) begin : g_link
    slc_link_tx u_tx (
      .hclk(hclk),
      .hresetn(hresetn),
      .enable(s_r.en[g]),
      .sym_gap(s_r.symgap[g]),
      .tok_gap(s_r.tokgap[g]),
      .greeting_token(s_r.greeting_token[g]),
      .rx_reset(s_r.rxrst[g]),
      .remote_credit(remote_credit[g]),
      .local_grant(local_grant[g]),
      .sym_valid(tx_sym_valid[g]),
      .sym_last(tx_sym_last[g]),
      .sym_ready(tx_sym_ready[g]),
      .credit_held(held[g]),
      .credit_issued(issued[g])
    );
    assign static_fwd_en[STATIC_LINK_MAP[g]] = s_r.st_en[g];
    assign static_fwd_proc[STATIC_LINK_MAP[g]] = s_r.st_proc[g];
    assign static_fwd_chan[STATIC_LINK_MAP[g]] = s_r.st_chan[g];
  end : g_link
endmodule : slc_top

// ### slc_checker.sv
// port assertions of the link control and status block
module slc_checker import slc_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // transmit and controls of all eight links
  input wire logic [7:0] tx_sym_valid,
  input wire logic [7:0] tx_sym_ready,
  input wire logic [7:0] link_enable,
  input wire logic [7:0] link_greeting_token,
  input wire logic [7:0] link_rx_reset,
  input wire logic [7:0][3:0] ext_dir
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_ph_r;
  // marks the data phase of a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_ph_r <= 1'b0;
    else wr_ph_r <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
  end
  sequence rd_taken;
    hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  AST_READ_WAIT: assert property (rd_taken |=> one_wait)
    else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (wr_ph_r |-> hreadyout)
    else $error("write data phase stalled");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("error response seen");
  AST_TX_NEEDS_EN: assert property (tx_sym_ready[0] |-> link_enable[0] && !link_greeting_token[0])
    else $error("ready while disabled or greeting");
  AST_SYM_IDLE: assert property (tx_sym_valid[0] && tx_sym_ready[0] |=> !tx_sym_ready[0])
    else $error("no idle after symbol");
  AST_GREETING_TOKEN_PULSE: assert property ($rose(link_greeting_token[0]) |=> !link_greeting_token[0])
    else $error("greeting pulse too long");
  AST_RXRST_PULSE: assert property ($rose(link_rx_reset[0]) |=> !link_rx_reset[0])
    else $error("receiver reset pulse too long");
  AST_EN_BY_WRITE: assert property (!$stable(link_enable) |-> $past(wr_ph_r))
    else $error("enable changed without write");
  AST_DIR_BY_WRITE: assert property (!$stable(ext_dir) |-> $past(wr_ph_r))
    else $error("direction changed without write");
endmodule : slc_checker

bind slc_top slc_checker u_slc_checker (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .tx_sym_valid, .tx_sym_ready, .link_enable, .link_greeting_token, .link_rx_reset, .ext_dir);

// ### slc_partner.sv
// remote switch model answering a greeting token with credit
module slc_partner (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link state seen from the far end
  input wire logic [7:0] link_greeting_token,
  input wire logic [7:0] link_enable,
  input wire logic [7:0] link_wide,
  // far end width and answer speed
  input wire logic [7:0] wide,
  input wire logic [7:0] slow,
  // credit issued to the near end
  output logic [7:0] remote_credit
);
  int cnt [8];
  // count down from greeting to a one cycle credit pulse
  always @(posedge hclk or negedge hresetn) begin
    for (int i = 0; i < 8; i++) begin
      if (!hresetn) begin
        cnt[i] <= 0;
        remote_credit[i] <= 1'b0;
      end else begin
        remote_credit[i] <= cnt[i] == 1;
        if (link_greeting_token[i] && link_enable[i] && link_wide[i] == wide[i]) cnt[i] <= slow[i] ? 6 : 1;
        else if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
      end
    end
  end
endmodule : slc_partner

// ### tb_switch_link_control_status.sv
// testbench of the link control and status block
module tb_switch_link_control_status import slc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic dbg_evt_core0 = 1'b0, dbg_evt_core1 = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d, x;
  logic [7:0][1:0] ext_src_type = '0, pl_src_type = '0, ext_net, pl_net;
  logic [7:0][7:0] ext_dest = '0, pl_dest = '0;
  logic [7:0] ext_junk = '0, ext_dst_use = '0, ext_src_use = '0, pl_junk = '0, pl_dst_use = '0, pl_src_use = '0;
  logic [7:0] rx_error = '0, remote_credit, local_grant = '0, tx_sym_valid = '0, tx_sym_last = '0, tx_sym_ready;
  logic [7:0] link_enable, link_wide, link_greeting_token, link_rx_reset, static_fwd_en, static_fwd_proc;
  logic [7:0] p_wide = '0, p_slow = '0;
  logic [7:0][3:0] ext_dir;
  logic [7:0][4:0] static_fwd_chan;
  int fails = 0, cmp_count = 0, now = 0, t0 = 0;
  int ltr [8] = '{2, 3, 0, 1, 6, 7, 4, 5};
  bit lastq [$];
  assign hready = hreadyout;
  // clock and cycle count
  always #25 hclk = ~hclk;
  always @(posedge hclk) now <= now + 1;
  slc_top u_slc_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .dbg_evt_core0, .dbg_evt_core1, .ext_src_type, .ext_dest, .ext_junk, .ext_dst_use,
    .ext_src_use, .pl_src_type, .pl_dest, .pl_junk, .pl_dst_use, .pl_src_use, .rx_error, .remote_credit,
    .local_grant, .tx_sym_valid, .tx_sym_last, .tx_sym_ready, .link_enable, .link_wide, .link_greeting_token,
    .link_rx_reset, .ext_dir, .ext_net, .pl_net, .static_fwd_en, .static_fwd_proc, .static_fwd_chan);
  slc_partner u_slc_partner (.hclk, .hresetn, .link_greeting_token, .link_enable, .link_wide, .wide(p_wide),
    .slow(p_slow), .remote_credit);
  task automatic report_and_stop();
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one single transfer, waiting for hready in each phase
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] i, input logic [31:0] v);
    logic [31:0] r;
    bus({22'h0, i, 2'h0}, 1'b1, v, r);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] i, input logic [31:0] e);
    logic [31:0] r;
    bus({22'h0, i, 2'h0}, 1'b0, 32'h0, r);
    chk(nm, e, r);
  endtask : rdc
  // watchdog
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    report_and_stop();
  end
  initial begin
    void'($urandom(1844));
    p_wide <= 8'h01;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      rdc("ext_reset", 8'(IDX_EXT_STAT + i), 32'h0);
      rdc("cfg_reset", 8'(IDX_CFG + i), 32'h0);
      rdc("static_reset", 8'(IDX_STATIC + i), 32'h0);
    end
    {ext_src_type, ext_junk, ext_dst_use, ext_src_use, pl_src_type, pl_junk, pl_dst_use, pl_src_use} <=
      80'({$urandom, $urandom, $urandom});
    ext_dest <= {$urandom, $urandom};
    pl_dest <= {$urandom, $urandom};
    // random writes to every bank, read back with live status
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      wr(8'(IDX_EXT_STAT + i), d);
      rdc("ext", 8'(IDX_EXT_STAT + i), {6'h0, ext_src_type[i], ext_dest[i], 4'h0, d[11:8], 2'h0, d[5:4], 1'b0,
        ext_junk[i], ext_dst_use[i], ext_src_use[i]});
      chk("ext_dir", 32'(d[11:8]), 32'(ext_dir[i]));
      chk("ext_net", 32'(d[5:4]), 32'(ext_net[i]));
      wr(8'(IDX_PL_STAT + i), d);
      rdc("pl", 8'(IDX_PL_STAT + i), {6'h0, pl_src_type[i], pl_dest[i], 8'h0, 2'h0, d[5:4], 1'b0,
        pl_junk[i], pl_dst_use[i], pl_src_use[i]});
      chk("pl_net", 32'(d[5:4]), 32'(pl_net[i]));
      wr(8'(IDX_STATIC + i), d);
      rdc("static", 8'(IDX_STATIC + i), d & 32'h8000_011F);
      chk("fwd", 32'({d[31], d[8], d[4:0]}), 32'({static_fwd_en[ltr[i]], static_fwd_proc[ltr[i]],
        static_fwd_chan[ltr[i]]}));
      d = $urandom & 32'hFE7F_FFFF;
      wr(8'(IDX_CFG + i), d);
      rdc("cfg", 8'(IDX_CFG + i), d & 32'hC03F_FFFF);
      chk("en_wide", 32'(d[31:30]), 32'({link_enable[i], link_wide[i]}));
    end
    wr(IDX_RSVD, 32'hFFFF_FFFF);
    rdc("rsvd", IDX_RSVD, 32'h0000_0003);
    wr(IDX_DBG, 32'hFFFF_FFFF);
    rdc("dbg", IDX_DBG, 32'h0000_0013);
    dbg_evt_core1 <= 1'b1;
    @(posedge hclk);
    dbg_evt_core1 <= 1'b0;
    rdc("dbg_one", IDX_DBG, 32'h0000_0012);
    dbg_evt_core0 <= 1'b1;
    @(posedge hclk);
    dbg_evt_core0 <= 1'b0;
    rdc("dbg_zero", IDX_DBG, 32'h0000_0011);
    bus(32'h0000_0480, 1'b0, 32'h0, x);
    chk("unmapped", 32'h0, x);
    // credit handshake on link zero
    wr(IDX_CFG, 32'hC000_1004);
    #1 chk("tx_ready", 32'h0, 32'(tx_sym_ready[0]));
    wr(IDX_CFG, 32'hC100_1004);
    #1 chk("greeting_token", 32'h1, 32'(link_greeting_token[0]));
    repeat (4) @(posedge hclk);
    rdc("held", IDX_CFG, 32'hC200_1004);
    local_grant[0] <= 1'b1;
    rx_error[0] <= 1'b1;
    @(posedge hclk);
    local_grant[0] <= 1'b0;
    rx_error[0] <= 1'b0;
    rdc("grant_err", IDX_CFG, 32'hCE00_1004);
    wr(IDX_CFG, 32'hC080_1004);
    #1 chk("rx_reset", 32'h1, 32'(link_rx_reset[0]));
    rdc("after_rx_reset", IDX_CFG, 32'hC200_1004);
    // symbol spacing inside and between tokens
    tx_sym_valid[0] <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      do @(posedge hclk); while (tx_sym_ready[0] !== 1'b1);
      if (k > 0) chk("sym_space", lastq.pop_front() ? 6 : 4, now - t0);
      lastq.push_back(tx_sym_last[0]);
      t0 = now;
      tx_sym_last[0] <= k % 3 == 1;
    end
    tx_sym_valid[0] <= 1'b0;
    p_slow <= 8'h01;
    wr(IDX_CFG, 32'hC100_1004);
    rdc("greeting_token_clear", IDX_CFG, 32'hC000_1004);
    repeat (10) @(posedge hclk);
    rdc("slow_credit", IDX_CFG, 32'hC200_1004);
    wr(8'(IDX_CFG + 1), 32'hC100_0000);
    repeat (10) @(posedge hclk);
    rdc("width_mismatch", 8'(IDX_CFG + 1), 32'hC000_0000);
    wr(IDX_CFG, 32'h0000_1004);
    rdc("disable", IDX_CFG, 32'h0000_1004);
    chk("tx_off", 32'h0, 32'(tx_sym_ready[0]));
    report_and_stop();
  end
endmodule : tb_switch_link_control_status
